// *** codec_cfg_pkg.sv ***
// package: command codes, field positions and reset values of the codec
// configuration bank; shared by the device end and the host controller end
package codec_cfg_pkg;
	localparam logic [7:0] CMD_CFG_WR      = 8'h46;
	localparam logic [7:0] CMD_CFG_RD      = 8'h47;
	localparam logic [7:0] CMD_CHEN_WR     = 8'h4A;
	localparam logic [7:0] CMD_CHEN_RD     = 8'h4B;
	localparam logic [7:0] CMD_RT_RD       = 8'h4D;
	localparam logic [7:0] CMD_RT_RD_CLR   = 8'h4F;
	localparam logic [7:0] CMD_GAIN_WR     = 8'h50;
	localparam logic [7:0] CMD_GAIN_RD     = 8'h51;
	localparam logic [7:0] CMD_IO_WR       = 8'h52;
	localparam logic [7:0] CMD_IO_RD       = 8'h53;
	localparam int         CMD_RD_BIT      = 0;
	localparam int         CMD_CLR_BIT     = 1;
	// global configuration fields
	localparam int         CFG_IRQ_STYLE   = 7;
	localparam int         CFG_CHOP_SEL    = 6;
	localparam int         CFG_HWY_SIG     = 5;
	localparam int         CFG_CLK_SRC     = 4;
	localparam int         CFG_FREQ_LSB    = 0;
	localparam logic [7:0] CFG_RESET       = 8'h9A;
	localparam logic [3:0] FREQ_RESET_CODE = 4'hA;
	// channel enable and mode fields
	localparam int         CHEN_RBE        = 6;
	localparam int         CHEN_IDLE       = 5;
	localparam int         CHEN_LPM        = 4;
	localparam logic [7:0] CHEN_RESET      = 8'h0F;
	// gain and impedance scaling fields
	localparam int         GAIN_TX         = 6;
	localparam int         GAIN_RX         = 5;
	localparam logic [7:0] GAIN_RESET      = 8'h00;
	localparam logic [4:0] ISCALE_LOOPBACK = 5'h10;
	localparam logic [4:0] ISCALE_CUTOFF   = 5'h00;
	localparam logic [4:0] ISCALE_OFFSET   = 5'h10;
	// line I/O latch
	localparam int         IO_MUX_BIT      = 5;
	localparam logic [7:0] IO_RESET        = 8'h00;
	localparam logic [7:0] MASK_RESET      = 8'hFF;
	// chopper: 2048 kHz reference divided by 8 or 7
	localparam logic [2:0] CHOP_DIV_SLOW   = 3'h7;
	localparam logic [2:0] CHOP_DIV_FAST   = 3'h6;
	// host controller register offsets (Avalon word addresses)
	localparam logic [1:0] HOST_CMD_OFS    = 2'h0;
	localparam logic [1:0] HOST_WDATA_OFS  = 2'h1;
	localparam logic [1:0] HOST_STAT_OFS   = 2'h2;
	localparam logic [1:0] HOST_RDATA_OFS  = 2'h3;
endpackage : codec_cfg_pkg

// *** codec_cmd_if.sv ***
// interface: byte-wide command link between host controller and codec bank
// assumes both ends share clk; one transfer per valid cycle
`timescale 1ns/10ps
`default_nettype none
interface codec_cmd_if;
	logic       cmd_valid;
	logic [7:0] cmd_code;
	logic [7:0] cmd_wdata;
	logic       rsp_valid;
	logic [7:0] rsp_data;
	modport device (input cmd_valid, cmd_code, cmd_wdata,
		output rsp_valid, rsp_data);
	modport host (output cmd_valid, cmd_code, cmd_wdata,
		input rsp_valid, rsp_data);
endinterface : codec_cmd_if
`default_nettype wire

// *** codec_cfg_bank.sv ***
// codec configuration bank: decodes command bytes, holds the registers,
// drives the derived controls; assumes one command per valid cycle
//
// The Avalon-MM slave port and the address map were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - config at 46h write, 47h read
// - irq style 0 TTL, 1 open drain
// - chopper 2048/8 default, 2048/7 when set
// - highway signaling only when bit set
// - clock source pin, E1 allowed if 1
// - shared master frequency, reset code 1010
// - config access ignores channel enables
// - channel enable and mode at 4Ah/4Bh
// - robbed bit only with mu-law
// - idle output resistor or high impedance
// - low power while all channels inactive
// - channel enables gate commands, reset 0Fh; bank gates none, only drives chan_cmd_enable
// - realtime read 4Dh keeps, 4Fh clears irq
// - realtime byte order B4 A4 .. B1 A1
// - realtime read ignores channel enables
// - gain register 50h/51h, 6.02 dB bits
// - scale gain 0.0625 times code minus 16
// - code 10000 loopback, zero cuts off
// - line I/O latch at 52h/53h
// - latch drives only pins set as output
// - pin1 mux bit valid only with E1
// - reserved bits written zero, read undefined
// - masked realtime bits raise no interrupt
module codec_cfg_bank
	import codec_cfg_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	codec_cmd_if.device      cmd,
	input  wire logic [3:0]  chan_active,
	input  wire logic        mu_law_select,
	input  wire logic        e1_mux_enable,
	input  wire logic [7:0]  irq_mask_bit,
	input  wire logic [7:0]  line_inputs,
	input  wire logic [4:0]  line_io_dir,
	input  wire logic        chop_ref_tick,
	output logic             irq_n_o,
	output logic             irq_n_oe,
	output logic             chopper_tick,
	output logic             highway_signaling_enable,
	output logic             master_clock_source,
	output logic             e1_mux_permitted,
	output logic [3:0]       master_freq_select,
	output logic             master_freq_reserved,
	output logic             robbed_bit_active,
	output logic [3:0]       analog_out_idle_hiz,
	output logic             low_power_active,
	output logic [3:0]       chan_cmd_enable,
	output logic             tx_gain_boost,
	output logic             rx_loss_insert,
	output logic signed [5:0] impedance_scale_gain,
	output logic             full_digital_loopback,
	output logic             impedance_cutoff,
	output logic [4:0]       line_io_o,
	output logic [4:0]       line_io_oe,
	output logic             line_io_pin1_mux_bit
);
	logic [7:0] cfg_reg;
	logic [7:0] chen_reg;
	logic [7:0] gain_reg;
	logic [7:0] io_reg;
	logic [7:0] rt_reg;
	logic       irq_pend_reg;
	logic [2:0] chop_cnt_reg;
	logic       rsp_valid_reg;
	logic [7:0] rsp_data_reg;
	logic       rt_change;

	function automatic logic is_cmd(input logic [7:0] code,
		input logic [7:0] want);
		is_cmd = cmd.cmd_valid && (code == want);
	endfunction : is_cmd

	// global configuration, no channel gating
	always_ff @(posedge clk) begin
		if (rst)
			cfg_reg <= CFG_RESET;
		else if (is_cmd(cmd.cmd_code, CMD_CFG_WR))
			cfg_reg <= cmd.cmd_wdata;
	end

	always_ff @(posedge clk) begin
		if (rst)
			chen_reg <= CHEN_RESET;
		else if (is_cmd(cmd.cmd_code, CMD_CHEN_WR))
			chen_reg <= cmd.cmd_wdata;
	end

	always_ff @(posedge clk) begin
		if (rst)
			gain_reg <= GAIN_RESET;
		else if (is_cmd(cmd.cmd_code, CMD_GAIN_WR))
			gain_reg <= cmd.cmd_wdata;
	end

	// latched for every pin, input or output
	always_ff @(posedge clk) begin
		if (rst)
			io_reg <= IO_RESET;
		else if (is_cmd(cmd.cmd_code, CMD_IO_WR))
			io_reg <= cmd.cmd_wdata;
	end

	// snapshot of line inputs; change detect for the interrupt
	always_ff @(posedge clk) begin
		if (rst)
			rt_reg <= 8'h00;
		else
			rt_reg <= line_inputs;
	end

	assign rt_change = |((rt_reg ^ line_inputs) & ~irq_mask_bit);

	// set wins over a clearing read in the same cycle
	always_ff @(posedge clk) begin
		if (rst)
			irq_pend_reg <= 1'b0;
		else if (rt_change)
			irq_pend_reg <= 1'b1;
		else if (is_cmd(cmd.cmd_code, CMD_RT_RD_CLR))
			irq_pend_reg <= 1'b0;
	end

	// read answers: one cycle after the command; reserved bits echo latch
	always_ff @(posedge clk) begin
		if (rst) begin
			rsp_valid_reg <= 1'b0;
			rsp_data_reg  <= 8'h00;
		end else begin
			rsp_valid_reg <= 1'b0;
			if (cmd.cmd_valid && cmd.cmd_code[CMD_RD_BIT]) begin
				rsp_valid_reg <= 1'b1;
				case (cmd.cmd_code)
				CMD_CFG_RD:    rsp_data_reg <= cfg_reg;
				CMD_CHEN_RD:   rsp_data_reg <= chen_reg;
				CMD_RT_RD,
				CMD_RT_RD_CLR: rsp_data_reg <= rt_reg;
				CMD_GAIN_RD:   rsp_data_reg <= gain_reg;
				CMD_IO_RD:     rsp_data_reg <= io_reg;
				default:       rsp_data_reg <= 8'h00;
				endcase
			end
		end
	end
	assign cmd.rsp_valid = rsp_valid_reg;
	assign cmd.rsp_data  = rsp_data_reg;

	// chopper: count 8 or 7 ticks of the 2048 kHz reference
	always_ff @(posedge clk) begin
		if (rst)
			chop_cnt_reg <= 3'h0;
		else if (chop_ref_tick) begin
			if (chop_cnt_reg >= (cfg_reg[CFG_CHOP_SEL] ? CHOP_DIV_FAST
				: CHOP_DIV_SLOW))
				chop_cnt_reg <= 3'h0;
			else
				chop_cnt_reg <= chop_cnt_reg + 3'h1;
		end
	end
	assign chopper_tick = chop_ref_tick && (chop_cnt_reg == 3'h0);

	// open drain drives only low; TTL drives both levels
	assign irq_n_o  = ~irq_pend_reg;
	assign irq_n_oe = cfg_reg[CFG_IRQ_STYLE] ? irq_pend_reg : 1'b1;

	assign highway_signaling_enable = cfg_reg[CFG_HWY_SIG];
	assign master_clock_source = cfg_reg[CFG_CLK_SRC];
	assign e1_mux_permitted = cfg_reg[CFG_CLK_SRC] && e1_mux_enable;
	assign master_freq_select = cfg_reg[CFG_FREQ_LSB +: 4];
	// codes 0-2, 4-6, 8-10 valid; low pair 11 or high pair 11 reserved
	assign master_freq_reserved = (cfg_reg[1:0] == 2'b11) ||
		(cfg_reg[3:2] == 2'b11);

	assign robbed_bit_active = chen_reg[CHEN_RBE] && mu_law_select;
	assign analog_out_idle_hiz = {4{chen_reg[CHEN_IDLE]}} & ~chan_active;
	assign low_power_active = chen_reg[CHEN_LPM] && (chan_active == 4'h0);
	assign chan_cmd_enable = chen_reg[3:0];

	assign tx_gain_boost  = gain_reg[GAIN_TX];
	assign rx_loss_insert = gain_reg[GAIN_RX];
	// gain in sixteenths: code minus 16
	assign impedance_scale_gain = $signed({1'b0, gain_reg[4:0]})
		- $signed({1'b0, ISCALE_OFFSET});
	assign full_digital_loopback = gain_reg[4:0] == ISCALE_LOOPBACK;
	assign impedance_cutoff = gain_reg[4:0] == ISCALE_CUTOFF;

	assign line_io_o  = io_reg[4:0];
	assign line_io_oe = line_io_dir;
	assign line_io_pin1_mux_bit = io_reg[IO_MUX_BIT] && e1_mux_enable;
endmodule : codec_cfg_bank
`default_nettype wire

// *** codec_host_ctrl.sv ***
// host controller: Avalon-MM slave that issues one command byte to the
// codec bank and captures the answer; assumes the bank answers in one cycle
`timescale 1ns/10ps
`default_nettype none
module codec_host_ctrl
	import codec_cfg_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [1:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	codec_cmd_if.host        cmd
);
	typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_SEND = 2'b01,
		ST_WAIT = 2'b11} state_t;
	state_t     state_reg;
	logic [7:0] wdata_reg;
	logic [7:0] code_reg;
	logic [7:0] rdata_reg;
	logic       busy;
	logic       start;

	assign busy  = state_reg != ST_IDLE;
	assign start = avs_write && !busy && avs_address == HOST_CMD_OFS;
	// a command write waits while a transfer runs; all else answers at once
	assign avs_waitrequest = (avs_write && avs_address == HOST_CMD_OFS
		&& busy);

	// reserved bits are the caller's to zero
	always_ff @(posedge clk) begin
		if (rst)
			wdata_reg <= 8'h00;
		else if (avs_write && avs_address == HOST_WDATA_OFS)
			wdata_reg <= avs_writedata[7:0];
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg <= ST_IDLE;
			code_reg  <= 8'h00;
		end else begin
			case (state_reg)
			ST_IDLE: if (start) begin
				code_reg  <= avs_writedata[7:0];
				state_reg <= ST_SEND;
			end
			// only the latched code decides; the bus may already carry more
			ST_SEND: state_reg <= code_reg[CMD_RD_BIT] ? ST_WAIT : ST_IDLE;
			ST_WAIT: if (cmd.rsp_valid)
				state_reg <= ST_IDLE;
			default: state_reg <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst)
			rdata_reg <= 8'h00;
		else if (state_reg == ST_WAIT && cmd.rsp_valid)
			rdata_reg <= cmd.rsp_data;
	end

	assign cmd.cmd_valid = state_reg == ST_SEND;
	assign cmd.cmd_code  = code_reg;
	assign cmd.cmd_wdata = wdata_reg;

	always_comb begin
		avs_readdata = 32'h0000_0000;
		if (avs_read) begin
			case (avs_address)
			HOST_CMD_OFS:   avs_readdata = {24'h00_0000, code_reg};
			HOST_WDATA_OFS: avs_readdata = {24'h00_0000, wdata_reg};
			HOST_STAT_OFS:  avs_readdata = {31'h000_0000, busy};
			default:        avs_readdata = {24'h00_0000, rdata_reg};
			endcase
		end
	end
endmodule : codec_host_ctrl
`default_nettype wire

// *** codec_link_chk.sv ***
// checker: answers and readback on the command link
// assumes it watches the link that joins host controller and bank
`timescale 1ns/10ps
`default_nettype none
module codec_link_chk
	import codec_cfg_pkg::*;
(
	input wire logic       clk,
	input wire logic       rst,
	input wire logic       cmd_valid,
	input wire logic [7:0] cmd_code,
	input wire logic [7:0] cmd_wdata,
	input wire logic       rsp_valid,
	input wire logic [7:0] rsp_data
);
	logic [7:0] cfg_reg, chen_reg, gain_reg, io_reg;
	// shadow of written bytes; reserved bits kept as written
	always_ff @(posedge clk) begin
		if (rst) begin
			cfg_reg  <= CFG_RESET;
			chen_reg <= CHEN_RESET;
			gain_reg <= GAIN_RESET;
			io_reg   <= IO_RESET;
		end else if (cmd_valid) begin
			if (cmd_code == CMD_CFG_WR) cfg_reg <= cmd_wdata;
			if (cmd_code == CMD_CHEN_WR) chen_reg <= cmd_wdata;
			if (cmd_code == CMD_GAIN_WR) gain_reg <= cmd_wdata;
			if (cmd_code == CMD_IO_WR) io_reg <= cmd_wdata;
		end
	end
	default clocking dc @(posedge clk); endclocking
	default disable iff (rst);
	sequence rd_req;
		cmd_valid && cmd_code[CMD_RD_BIT];
	endsequence
	sequence rd_of(c);
		cmd_valid && cmd_code == c;
	endsequence
	rd_answer_a: assert property (rd_req |=> rsp_valid)
		else $error("read got no answer");
	wr_silent_a: assert property (
		cmd_valid && !cmd_code[CMD_RD_BIT] |=> !rsp_valid)
		else $error("write got an answer");
	rsp_cause_a: assert property (
		rsp_valid |-> $past(cmd_valid) && $past(cmd_code[CMD_RD_BIT]))
		else $error("answer without read");
	rsp_hold_a: assert property (
		rsp_valid ##1 !rsp_valid |-> $stable(rsp_data))
		else $error("answer data moved");
	cfg_back_a: assert property (rd_of(CMD_CFG_RD) |=> rsp_data == cfg_reg)
		else $error("config readback wrong");
	chen_back_a: assert property (rd_of(CMD_CHEN_RD) |=> rsp_data == chen_reg)
		else $error("mode readback wrong");
	gain_back_a: assert property (rd_of(CMD_GAIN_RD) |=> rsp_data == gain_reg)
		else $error("gain readback wrong");
	io_back_a: assert property (rd_of(CMD_IO_RD) |=> rsp_data == io_reg)
		else $error("io readback wrong");
endmodule : codec_link_chk
`default_nettype wire

// *** test_quad_codec_config_registers.sv ***
// bench: host controller and bank joined by the command link
// assumes 20 MHz clk; software reaches the bank only over Avalon-MM
`timescale 1ns/10ps
`default_nettype none
module test_quad_codec_config_registers
	import codec_cfg_pkg::*;
;
	logic        clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
	logic [1:0]  avs_address = 2'h0;
	logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata;
	logic        avs_waitrequest, mu_law_select = 1'b1, e1_mux_enable = 1'b0;
	logic [3:0]  chan_active = 4'h0, analog_out_idle_hiz, chan_cmd_enable;
	logic [7:0]  irq_mask_bit = 8'hff, line_inputs = 8'h00, junk;
	logic [4:0]  line_io_dir = 5'h00, line_io_o, line_io_oe;
	logic        chop_ref_tick = 1'b0, irq_n_o, irq_n_oe, chopper_tick;
	logic        highway_signaling_enable, master_clock_source;
	logic        e1_mux_permitted, master_freq_reserved, robbed_bit_active;
	logic        low_power_active, tx_gain_boost, rx_loss_insert;
	logic        full_digital_loopback, impedance_cutoff, line_io_pin1_mux_bit;
	logic [3:0]  master_freq_select;
	logic signed [5:0] impedance_scale_gain;
	int          failures = 0, num_checks = 0, cyc = 0;
	codec_cmd_if link();
	codec_cfg_bank u_codec_cfg_bank(.cmd(link), .*);
	codec_host_ctrl u_codec_host_ctrl(.cmd(link), .*);
	codec_link_chk u_codec_link_chk(.clk(clk), .rst(rst),
		.cmd_valid(link.cmd_valid), .cmd_code(link.cmd_code),
		.cmd_wdata(link.cmd_wdata), .rsp_valid(link.rsp_valid),
		.rsp_data(link.rsp_data));
	always #25 clk = ~clk;
	task automatic chk(input string what, input logic [7:0] exp, got);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// request held to the edge that samples waitrequest low; data taken there
	task automatic av(input logic wr, input logic [1:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge clk);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= d;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask : av
	task automatic cmd(input logic [7:0] code, wd, output logic [7:0] q);
		logic [31:0] r;
		av(1'b1, HOST_WDATA_OFS, {24'h00_0000, wd}, r);
		av(1'b1, HOST_CMD_OFS, {24'h00_0000, code}, r);
		do av(1'b0, HOST_STAT_OFS, 32'h0000_0000, r); while (r[0] !== 1'b0);
		av(1'b0, HOST_RDATA_OFS, 32'h0000_0000, r);
		q = r[7:0];
	endtask : cmd
	task automatic rd(input logic [7:0] code, exp, input string what);
		logic [7:0] q;
		cmd(code, 8'h00, q);
		chk(what, exp, q);
	endtask : rd
	task automatic t_reset;
		chk("irq oe", 8'h00, {7'h00, irq_n_oe});
		chk("cfg outs", 8'h3a, {3'h1, master_clock_source, master_freq_select});
		rd(CMD_CFG_RD, 8'h9a, "cfg");
		rd(CMD_CHEN_RD, 8'h0f, "chen");
		rd(CMD_GAIN_RD, 8'h00, "gain");
	endtask : t_reset
	task automatic t_cfg;
		e1_mux_enable <= 1'b1;
		cmd(CMD_CHEN_WR, 8'h00, junk);
		cmd(CMD_CFG_WR, 8'h45, junk);
		rd(CMD_CFG_RD, 8'h45, "cfg");
		chk("irq oe", 8'h01, {7'h00, irq_n_oe});
		chk("cfg outs", 8'h05, {master_freq_reserved, highway_signaling_enable,
			master_clock_source, e1_mux_permitted, master_freq_select});
		cmd(CMD_CFG_WR, 8'h3a, junk);
		chk("cfg outs", 8'h7a, {master_freq_reserved, highway_signaling_enable,
			master_clock_source, e1_mux_permitted, master_freq_select});
	endtask : t_cfg
	task automatic t_chen;
		cmd(CMD_CHEN_WR, 8'h75, junk);
		chk("mode", 8'hcf, {robbed_bit_active, low_power_active, 2'b00, analog_out_idle_hiz});
		chk("enables", 8'h05, {4'h0, chan_cmd_enable});
		chan_active <= 4'h1;
		mu_law_select <= 1'b0;
		repeat (2) @(posedge clk);
		chk("mode", 8'h0e, {robbed_bit_active, low_power_active, 2'b00, analog_out_idle_hiz});
	endtask : t_chen
	task automatic t_gain;
		logic [7:0] g[3] = '{8'h10, 8'h00, 8'h71};
		// sixteenths: 0, -16, +1; outs: boost, loss, loopback, cutoff
		logic [7:0] s[3] = '{8'h00, 8'h30, 8'h01};
		logic [7:0] o[3] = '{8'h02, 8'h01, 8'h0c};
		foreach (g[i]) begin
			cmd(CMD_GAIN_WR, g[i], junk);
			chk("scale", s[i], {2'b00, impedance_scale_gain});
			chk("gain outs", o[i], {4'h0, tx_gain_boost, rx_loss_insert,
				full_digital_loopback, impedance_cutoff});
		end
	endtask : t_gain
	task automatic t_io;
		line_io_dir <= 5'h15;
		cmd(CMD_IO_WR, 8'h3f, junk);
		chk("io", 8'h3f, {2'b00, line_io_pin1_mux_bit, line_io_o});
		chk("io oe", 8'h15, {3'h0, line_io_oe});
		e1_mux_enable <= 1'b0;
		repeat (2) @(posedge clk);
		chk("io", 8'h1f, {2'b00, line_io_pin1_mux_bit, line_io_o});
		rd(CMD_IO_RD, 8'h3f, "io");
	endtask : t_io
	task automatic t_irq;
		irq_mask_bit <= 8'hfe;
		line_inputs <= 8'ha6;
		repeat (3) @(posedge clk);
		chk("irq", 8'h01, {7'h00, irq_n_o});
		line_inputs <= 8'ha7;
		repeat (3) @(posedge clk);
		chk("irq", 8'h00, {7'h00, irq_n_o});
		rd(CMD_RT_RD, 8'ha7, "realtime");
		chk("irq", 8'h00, {7'h00, irq_n_o});
		rd(CMD_RT_RD_CLR, 8'ha7, "realtime");
		chk("irq", 8'h01, {7'h00, irq_n_o});
	endtask : t_irq
	// reset in mid-run drops a pending irq; open drain drives only while set
	task automatic t_rerst;
		line_inputs <= 8'ha6;
		repeat (3) @(posedge clk);
		chk("irq", 8'h00, {7'h00, irq_n_o});
		rst <= 1'b1;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk("irq pins", 8'h01, {6'h00, irq_n_oe, irq_n_o});
		rd(CMD_CFG_RD, 8'h9a, "cfg");
		line_inputs <= 8'ha7;
		repeat (3) @(posedge clk);
		chk("irq pins", 8'h02, {6'h00, irq_n_oe, irq_n_o});
		rd(CMD_RT_RD_CLR, 8'ha7, "realtime");
		chk("irq pins", 8'h01, {6'h00, irq_n_oe, irq_n_o});
	endtask : t_rerst
	// 56 reference ticks: 7 chopper ticks by 8, then 8 by 7
	task automatic t_chop;
		logic [7:0] n;
		cmd(CMD_CFG_WR, 8'h9f, junk);
		chk("freq reserved", 8'h01, {7'h00, master_freq_reserved});
		for (int p = 0; p < 2; p++) begin
			n = 8'h00;
			chop_ref_tick <= 1'b1;
			repeat (56) begin
				@(posedge clk);
				if (chopper_tick === 1'b1)
					n++;
			end
			chop_ref_tick <= 1'b0;
			chk("chopper ticks", (p != 0) ? 8'h08 : 8'h07, n);
			cmd(CMD_CFG_WR, 8'hda, junk);
		end
	endtask : t_chop
	task automatic end_of_test;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : end_of_test
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			end_of_test();
		end
	end
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_cfg();
		t_chen();
		t_gain();
		t_io();
		t_irq();
		t_rerst();
		t_chop();
		end_of_test();
	end
endmodule : test_quad_codec_config_registers
`default_nettype wire
